// ### test/restart_interlock_contactor_check_tb.sv
// bench for the restart interlock and contactor check
// assumes short counts: CHECK_CYCLES 50, DB_CYCLES 4
`define CHK(a, b) \
	begin \
		tests_run++; \
		if ((a) !== (b)) \
		begin \
			miscompares++; \
			$display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); \
		end \
	end
module restart_interlock_contactor_check_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk, rst_b, field_clear, push, slow, sw_r, sw_m;
	logic        wr_stb, rd_stb, out_1, out_2, irq, ack_pin, fb_pin;
	logic [3:0]  addr;
	logic [31:0] wr_data, rd_data;
	int          miscompares, tests_run;
	rilc_top #(.CHECK_CYCLES(50), .DB_CYCLES(4)) rilc_top_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .field_clear(field_clear),
		.ack_pin(ack_pin), .fb_pin(fb_pin), .sw_restart_pin(sw_r),
		.sw_monitor_pin(sw_m), .safety_switching_output_1(out_1),
		.safety_switching_output_2(out_2), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq));
	rilc_partner rilc_partner_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .push(push), .slow(slow),
		.out_1(out_1), .out_2(out_2), .ack_pin(ack_pin), .fb_pin(fb_pin));
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task results;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task rst;
		rst_b <= 1'b0;
		tick(2);
		rst_b <= 1'b1;
		tick(4);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		addr    <= a;
		wr_data <= d;
		wr_stb  <= 1'b1;
		tick(1);
		wr_stb <= 1'b0;
		tick(1);
	endtask
	// read data only stand in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [31:0] e);
		addr   <= a;
		rd_stb <= 1'b1;
		tick(1);
		rd_stb <= 1'b0;
		#1 `CHK(rd_data, e)
		tick(1);
	endtask
	task wo(input logic v);
		for (int i = 0; i < 200 && out_1 !== v; i++)
			@(posedge sys_clk) #1;
		`CHK(out_1, v)
		`CHK(out_2, out_1)
		if (out_1 !== v)
			results();
	endtask
	task press(input int n);
		push <= 1'b1;
		tick(n);
		push <= 1'b0;
		tick(12);
	endtask
	task t_plain;
		rd(4'h8, 32'h0);
		rd(4'h4, 32'h0);
		wr(4'h4, 32'h7);
		field_clear <= 1'b1;
		wo(1'b1);
		rd(4'h8, 32'h1);
		field_clear <= 1'b0;
		wo(1'b0);
		rd(4'h0, 32'h1);
		`CHK(irq, 1'b1)
		wr(4'h0, 32'h1);
		rd(4'h0, 32'h0);
		`CHK(irq, 1'b0)
		rd(4'hc, 32'h0);
	endtask
	task t_restart;
		sw_r        <= 1'b1; // no blanking mode to set up first
		field_clear <= 1'b1;
		rst;
		`CHK(out_1, 1'b0)
		press(2);
		`CHK(out_1, 1'b0)
		rd(4'h8, 32'h12);
		press(10);
		wo(1'b1);
		rd(4'h0, 32'h2);
		field_clear <= 1'b0;
		wo(1'b0);
		press(10);
		field_clear <= 1'b1;
		tick(20);
		`CHK(out_1, 1'b0)
		press(10);
		wo(1'b1);
	endtask
	task t_monitor;
		sw_r        <= 1'b0;
		sw_m        <= 1'b1;
		field_clear <= 1'b0;
		rst;
		field_clear <= 1'b1;
		wo(1'b1);
		tick(60);
		`CHK(out_1, 1'b1)
		rd(4'h8, 32'h5);
		field_clear <= 1'b0;
		wo(1'b0);
		slow        <= 1'b1;
		field_clear <= 1'b1;
		wo(1'b1);
		tick(60);
		`CHK(out_1, 1'b0)
		rd(4'h8, 32'hc);
		rd(4'h0, 32'h5);
	endtask
	initial
	begin
		{field_clear, push, slow, sw_r, sw_m, wr_stb, rd_stb} = 7'h00;
		addr    = 4'h0;
		wr_data = 32'h0;
		rst_b   = 1'b0;
		rst;
		t_plain;
		t_restart;
		t_monitor;
		results;
	end
endmodule // restart_interlock_contactor_check_tb

// ### test/rilc_partner.sv
// acknowledge button and two-channel contactor model
// assumes the bench drives push and slow on sys_clk edges
module rilc_partner
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// bench control
	input  wire logic push,
	input  wire logic slow,
	// safety outputs
	input  wire logic out_1,
	input  wire logic out_2,
	// pins
	output logic      ack_pin,
	output logic      fb_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [11:0] cnt;
	// normally-open contact, high only while pressed
	assign ack_pin = push;
	// slow models a sluggish contactor that misses the window
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt    <= 12'h000;
			fb_pin <= 1'b1;
		end
		else if (!(out_1 && out_2))
		begin
			cnt    <= 12'h000;
			fb_pin <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 12'h001;
			if (cnt == (slow ? 12'h3e8 : 12'h00a))
				fb_pin <= 1'b0;
		end
	end
endmodule // rilc_partner

// ### verilog/rilc_debounce.sv
// two-stage synchroniser and debouncer for the acknowledge pin
// assumes the pin is asynchronous to sys_clk
module rilc_debounce
	import rilc_pkg::*;
#(
	parameter int CYCLES = DEBOUNCE_CYCLES
)
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// pin side
	input  wire logic pin_raw,
	// debounced side
	output logic      level,
	output logic      rise
);

	typedef struct packed
	{
		logic                s1;
		logic                s2;
		logic                lvl;
		logic                rise;
		logic [DB_CNT_W-1:0] cnt;
	} rilc_db_s;

	rilc_db_s q_reg;
	rilc_db_s q_next;

	always_comb
	begin
		q_next      = q_reg;
		q_next.s1   = pin_raw;
		q_next.s2   = q_reg.s1;
		q_next.rise = 1'b0;
		// level must stay put for the full window before it is believed
		if (q_reg.s2 == q_reg.lvl)
		begin
			q_next.cnt = '0;
		end
		else if (q_reg.cnt == DB_CNT_W'(CYCLES - 1))
		begin
			q_next.cnt  = '0;
			q_next.lvl  = q_reg.s2;
			q_next.rise = q_reg.s2;
		end
		else
		begin
			q_next.cnt = q_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q_reg <= '0;
		end
		else
		begin
			q_reg <= q_next;
		end
	end

	assign level = q_reg.lvl;
	assign rise  = q_reg.rise;

endmodule // rilc_debounce

// ### verilog/rilc_pkg.sv
// constants, types and layout for the restart interlock and contactor check
// assumes one 100 MHz clock and a field-clear level from the beam logic
// What this block does
// - powers up plain safety mode, no interlocks, while both switches are off
// - restart inhibit holds outputs off until acknowledge
// - restart inhibit always brings start-up inhibit
// - start-up inhibit: outputs off until first acknowledge
// - contactors must switch within 200 ms
// - switching seen as falling contactor feedback edge
// - restart switch selects restart and start-up inhibit
// - separate switch selects contactor monitoring
// - both interlock functions inactive by default
// - two redundant outputs always switch together
package rilc_pkg;

	// timing
	localparam int CLK_FREQ_KHZ     = 100_000;
	localparam int SWITCH_TIME_MS   = 200;
	localparam int SWITCH_CYCLES    = SWITCH_TIME_MS * CLK_FREQ_KHZ;
	localparam int DEBOUNCE_TIME_MS = 10;
	localparam int DEBOUNCE_CYCLES  = DEBOUNCE_TIME_MS * CLK_FREQ_KHZ;
	localparam int CNT_W            = 25;
	localparam int DB_CNT_W         = 20;

	// register port
	localparam int              ADDR_W     = 4;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_STATE  = 4'h8;

	// event bits, same layout in status and mask
	localparam int         EV_W          = 3;
	localparam int         EV_FIELD_LOST = 0;
	localparam int         EV_ACK        = 1;
	localparam int         EV_FAULT      = 2;
	localparam logic [2:0] EV_RESET      = 3'h0;
	localparam logic [2:0] MASK_RESET    = 3'h0;

	// state register bits
	localparam int ST_B_OUT     = 0;
	localparam int ST_B_RESTART = 1;
	localparam int ST_B_MONITOR = 2;
	localparam int ST_B_LOCK    = 3;
	localparam int ST_B_WAIT    = 4;

	// synchronised pin inputs
	localparam int         IN_W          = 3;
	localparam int         IN_FB         = 0;
	localparam int         IN_SW_RESTART = 1;
	localparam int         IN_SW_MONITOR = 2;
	// feedback idles high, switches idle off
	localparam logic [2:0] SYNC_RESET    = 3'h1;

	typedef enum logic [3:0]
	{
		RILC_OFF   = 4'h1,
		RILC_CHECK = 4'h2,
		RILC_ON    = 4'h4,
		RILC_LOCK  = 4'h8
	} rilc_state_e;

endpackage

// ### verilog/rilc_top.sv
// safety output interlock: restart/start-up inhibit and contactor check
// assumes field_clear comes from beam logic on sys_clk; pins are asynchronous
//
// Implementation choices: the address map and the plain strobed port.
module rilc_top
	import rilc_pkg::*;
#(
	parameter int CHECK_CYCLES = SWITCH_CYCLES,
	parameter int DB_CYCLES    = DEBOUNCE_CYCLES
)
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// beam logic
	input  wire logic              field_clear,
	// pins from the installation
	input  wire logic              ack_pin,
	input  wire logic              fb_pin,
	input  wire logic              sw_restart_pin,
	input  wire logic              sw_monitor_pin,
	// safety outputs
	output logic                   safety_switching_output_1,
	output logic                   safety_switching_output_2,
	// register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [31:0]       wr_data,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic [31:0]            rd_data,
	// interrupt
	output logic                   irq
);

	typedef struct packed
	{
		rilc_state_e       st;
		logic [CNT_W-1:0]  cnt;
		logic [IN_W-1:0]   s1;
		logic [IN_W-1:0]   s2;
		logic              fb_d;
		logic [EV_W-1:0]   status;
		logic [EV_W-1:0]   mask;
		logic [31:0]       rd;
		logic [1:0]        warm;
	} rilc_top_s;

	rilc_top_s q_reg;
	rilc_top_s q_next;

	logic            ack_level;
	logic            ack_rise;
	logic            restart_en;
	logic            monitor_en;
	logic            fb;
	logic            fb_fall;
	logic            out_on;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] w1c;

	rilc_debounce #(
		.CYCLES (DB_CYCLES)
	) u_ack (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.pin_raw (ack_pin),
		.level   (ack_level),
		.rise    (ack_rise)
	);

	// switches are read live; start-up inhibit rides on the restart switch
	assign restart_en = q_reg.s2[IN_SW_RESTART];
	assign monitor_en = q_reg.s2[IN_SW_MONITOR];
	assign fb         = q_reg.s2[IN_FB];
	assign fb_fall    = q_reg.fb_d & ~fb;
	assign out_on     = (q_reg.st == RILC_CHECK) || (q_reg.st == RILC_ON);
	assign w1c        = (wr_stb && addr == OFS_STATUS) ? wr_data[EV_W-1:0] : '0;

	always_comb
	begin
		q_next      = q_reg;
		ev          = '0;
		q_next.s1   = {sw_monitor_pin, sw_restart_pin, fb_pin};
		q_next.s2   = q_reg.s1;
		q_next.fb_d = fb;
		// switch levels are stale until both synchroniser stages have filled
		q_next.warm = {q_reg.warm[0], 1'b1};
		case (q_reg.st)
			RILC_OFF:
			begin
				// acknowledge only counts with the field clear
				if (q_reg.warm[1] && field_clear
					&& (!restart_en || ack_rise))
				begin
					q_next.st     = RILC_CHECK;
					q_next.cnt    = '0;
					ev[EV_ACK]    = restart_en;
				end
			end
			RILC_CHECK:
			begin
				if (!field_clear)
				begin
					q_next.st         = RILC_OFF;
					ev[EV_FIELD_LOST] = 1'b1;
				end
				else if (!monitor_en || fb_fall)
				begin
					q_next.st = RILC_ON;
				end
				else if (q_reg.cnt == CNT_W'(CHECK_CYCLES - 1))
				begin
					q_next.st    = RILC_LOCK;
					ev[EV_FAULT] = 1'b1;
				end
				else
				begin
					q_next.cnt = q_reg.cnt + 1'b1;
				end
			end
			RILC_ON:
			begin
				if (!field_clear)
				begin
					q_next.st         = RILC_OFF;
					ev[EV_FIELD_LOST] = 1'b1;
				end
			end
			RILC_LOCK:
			begin
				// only a reset leaves the lockout
				q_next.st = RILC_LOCK;
			end
			default:
			begin
				q_next.st = RILC_LOCK;
			end
		endcase
		// a new event beats a clear in the same cycle
		q_next.status = (q_reg.status & ~w1c) | ev;
		if (wr_stb && addr == OFS_MASK)
		begin
			q_next.mask = wr_data[EV_W-1:0];
		end
		q_next.rd = '0;
		if (rd_stb)
		begin
			case (addr)
				OFS_STATUS: q_next.rd[EV_W-1:0] = q_reg.status;
				OFS_MASK:   q_next.rd[EV_W-1:0] = q_reg.mask;
				OFS_STATE:
				begin
					q_next.rd[ST_B_OUT]     = out_on;
					q_next.rd[ST_B_RESTART] = restart_en;
					q_next.rd[ST_B_MONITOR] = monitor_en;
					q_next.rd[ST_B_LOCK]    = q_reg.st == RILC_LOCK;
					q_next.rd[ST_B_WAIT]    = (q_reg.st == RILC_OFF) && restart_en;
				end
				default:    q_next.rd = '0;
			endcase
		end
	end

	// power-up lands in off with plain mode unless a switch says otherwise
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q_reg        <= '0;
			q_reg.st     <= RILC_OFF;
			q_reg.s1     <= SYNC_RESET;
			q_reg.s2     <= SYNC_RESET;
			q_reg.fb_d   <= 1'b1;
			q_reg.status <= EV_RESET;
			q_reg.mask   <= MASK_RESET;
		end
		else
		begin
			q_reg <= q_next;
		end
	end

	// both channels from one decode so they never disagree
	assign safety_switching_output_1 = out_on;
	assign safety_switching_output_2 = out_on;
	assign rd_data                   = q_reg.rd;
	assign irq                       = |(q_reg.status & q_reg.mask);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_turn_on;
		q_reg.warm[1] && q_reg.st == RILC_OFF && field_clear && (!restart_en || ack_rise);
	endsequence

	sequence s_on_checked;
		q_reg.st == RILC_CHECK ##0 safety_switching_output_1;
	endsequence

	property p_outs_equal;
		safety_switching_output_1 == safety_switching_output_2;
	endproperty
	a_outs_equal: assert property (p_outs_equal)
		else $error("safety outputs differ");

	property p_plain_on;
		q_reg.warm[1] && !restart_en && q_reg.st == RILC_OFF && field_clear
			|=> s_on_checked;
	endproperty
	a_plain_on: assert property (p_plain_on)
		else $error("plain mode did not switch on");

	property p_restart_hold;
		restart_en && q_reg.st == RILC_OFF && !ack_rise |=> !safety_switching_output_1;
	endproperty
	a_restart_hold: assert property (p_restart_hold)
		else $error("outputs on without acknowledge");

	property p_ack_blocked;
		q_reg.st == RILC_OFF && !field_clear |=> !safety_switching_output_2;
	endproperty
	a_ack_blocked: assert property (p_ack_blocked)
		else $error("switched on with field interrupted");

	property p_turn_on;
		s_turn_on |=> s_on_checked ##1 (safety_switching_output_1 || !$past(field_clear));
	endproperty
	a_turn_on: assert property (p_turn_on)
		else $error("accepted acknowledge did not enable");

	property p_timeout;
		q_reg.st == RILC_CHECK && field_clear && monitor_en && !fb_fall
			&& q_reg.cnt == CNT_W'(CHECK_CYCLES - 1)
			|=> q_reg.st == RILC_LOCK && !safety_switching_output_1 && q_reg.status[EV_FAULT];
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("missing feedback edge not locked out");

	property p_lock_off;
		q_reg.st == RILC_LOCK |=> q_reg.st == RILC_LOCK && !safety_switching_output_2;
	endproperty
	a_lock_off: assert property (p_lock_off)
		else $error("lockout left or outputs on");

	property p_fb_edge;
		q_reg.st == RILC_CHECK && field_clear && $past(fb) && !fb |=> q_reg.st == RILC_ON;
	endproperty
	a_fb_edge: assert property (p_fb_edge)
		else $error("feedback fall not accepted");

	property p_cnt_bound;
		q_reg.st == RILC_CHECK |-> q_reg.cnt < CNT_W'(CHECK_CYCLES);
	endproperty
	a_cnt_bound: assert property (p_cnt_bound)
		else $error("switching time exceeded");

	property p_no_monitor;
		q_reg.st == RILC_CHECK && !monitor_en && field_clear |=> q_reg.st == RILC_ON;
	endproperty
	a_no_monitor: assert property (p_no_monitor)
		else $error("check ran with monitoring off");

	property p_field_drop;
		safety_switching_output_1 && !field_clear
			|=> !safety_switching_output_1 && q_reg.status[EV_FIELD_LOST];
	endproperty
	a_field_drop: assert property (p_field_drop)
		else $error("field loss did not drop outputs");

	sequence s_warming;
		!q_reg.warm[1];
	endsequence

	property p_warm_hold;
		s_warming |=> !safety_switching_output_1;
	endproperty
	a_warm_hold: assert property (p_warm_hold)
		else $error("outputs on before switches settled");

	property p_ack_event;
		s_turn_on ##0 restart_en |=> q_reg.status[EV_ACK];
	endproperty
	a_ack_event: assert property (p_ack_event)
		else $error("accepted acknowledge not flagged");

	property p_check_hold;
		q_reg.st == RILC_CHECK && field_clear && monitor_en && !fb_fall
			&& q_reg.cnt != CNT_W'(CHECK_CYCLES - 1)
			|=> s_on_checked ##0 q_reg.cnt == $past(q_reg.cnt) + 1'b1;
	endproperty
	a_check_hold: assert property (p_check_hold)
		else $error("outputs dropped inside switching window");

	property p_on_hold;
		q_reg.st == RILC_ON && field_clear
			|=> q_reg.st == RILC_ON && safety_switching_output_2;
	endproperty
	a_on_hold: assert property (p_on_hold)
		else $error("outputs dropped with field clear");

	property p_lock_flag;
		$rose(q_reg.st == RILC_LOCK) |-> q_reg.status[EV_FAULT];
	endproperty
	a_lock_flag: assert property (p_lock_flag)
		else $error("lockout without fault flag");

	property p_wait_bit;
		rd_stb && addr == OFS_STATE && restart_en && q_reg.st == RILC_OFF
			|=> rd_data[ST_B_WAIT] && !rd_data[ST_B_OUT];
	endproperty
	a_wait_bit: assert property (p_wait_bit)
		else $error("waiting state not reported");

endmodule // rilc_top
